// ==== hdl/sesf_pkg.sv ====
package sesf_pkg;
   // ***********************************************************
   // Register map (byte addresses, index times four)
   // ***********************************************************
   localparam logic [7:0] SESF_IDX_CNT0 = 8'h00;
   localparam logic [7:0] SESF_IDX_CNT1 = 8'h01;
   localparam logic [7:0] SESF_IDX_CNT2 = 8'h02;
   localparam logic [7:0] SESF_IDX_MASK0 = 8'h03;
   localparam logic [7:0] SESF_IDX_MASK1 = 8'h06;
   localparam logic [7:0] SESF_IDX_STAT0 = 8'h07;
   localparam logic [7:0] SESF_IDX_STAT1 = 8'h08;
   localparam logic [7:0] SESF_IDX_SIGNAL = 8'h09;
   localparam logic [7:0] SESF_IDX_CTRL = 8'h0A;
   localparam logic [7:0] SESF_IDX_CTRL0 = 8'h07;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int SESF_ST_CNT_ZERO = 0;
   localparam int SESF_ST_PHASE_ATN = 1;
   localparam int SESF_ST_REQ_SEEN = 2;
   localparam int SESF_ST_PARITY = 3;
   localparam int SESF_ST_BUS_FREE = 4;
   localparam int SESF_ST_WRONG_PHASE = 5;
   localparam int SESF_ST1_ERROR = 4;
   localparam int SESF_M0_AUTO_ATTENTION_ON_PARITY = 4;
   localparam int SESF_M0_ERR_EN = 4;
   localparam int SESF_M1_PARITY_EN = 1;
   localparam int SESF_M1_BUS_FREE_EN = 2;
   localparam int SESF_M1_REQ_EN = 6;
   localparam int SESF_CTRL_TARGET = 0;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0] SESF_RST_CNT = 8'h00;
   localparam logic [7:0] SESF_RST_MASK = 8'h00;
   localparam logic [2:0] SESF_RST_PHASE = 3'h0;
   localparam logic [7:0] SESF_RST_CTRL = 8'h00;
endpackage

// ==== hdl/sesf_flags.sv ====
`timescale 1ns/1ps
// What this block does
// - Count-zero flag set when all count bytes zero
// - Loading a nonzero count clears count-zero flag
// - Initiator: phase line change sets phase flag
// - Initiator: ACK assertion clears phase flag
// - Target: ATN assertion sets phase flag
// - Cause-specific status flags set error summary
// - Initiator: REQ assertion sets request-seen flag
// - ACK assertion clears request-seen flag
// - Target: request-seen flag unused
// - Enabled parity error raises interrupt, flag, summary
// - Initiator keeps transferring after parity error
// - Initiator: auto-attention drives ATN on parity error
// - Writing parity enable zero clears parity flag
// - Bus free phase sets bus-free flag
// - Writing bus-free enable zero clears flag
// - Bus-free or mismatch also sets summary bit
// - Initiator: REQ with wrong phase sets mismatch
// - Writing matching expected phase clears mismatch
// - Request-seen flag sits at bit two
module sesf_flags #(
   parameter int ADDR_W = 8
)(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic scsi_req_i,
   input wire logic scsi_ack_i,
   input wire logic scsi_atn_i,
   input wire logic scsi_bsy_i,
   input wire logic scsi_sel_i,
   input wire logic [2:0] scsi_phase_i,
   input wire logic parity_err_i,
   output logic scsi_atn_o,
   output logic scsi_atn_oe_o,
   output logic int_o
);
   // Index must fit the eight-bit register decode
   if (ADDR_W < 6 || ADDR_W > 10)
   begin : g_bad_addr_w
      $error("ADDR_W outside the range the decode serves");
   end

   // ***********************************************************
   // Bus decode
   // ***********************************************************
   logic [7:0] idx;
   logic acc;
   logic wr;
   logic ack_q;
   assign idx = 8'(wb_adr_i[ADDR_W-1:2]);
   assign acc = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = acc && wb_we_i && wb_sel_i[0];

   // Registered ack after one wait state, dropped the cycle after
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= acc;
   end
   assign wb_ack_o = ack_q;

   // ***********************************************************
   // Software registers
   // ***********************************************************
   logic [7:0] cnt_q [3];
   logic [7:0] mask0_q;
   logic [7:0] mask1_q;
   logic [2:0] exp_phase_q;
   logic [7:0] ctrl_q;
   logic cnt_load;
   logic phase_wr;
   logic par_clr;
   logic bf_clr;
   logic target;
   assign target = ctrl_q[sesf_pkg::SESF_CTRL_TARGET];

   // Transfer count bytes
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_cnt
         always_ff @(posedge clock_i or posedge rst_i)
         begin
            if (rst_i)
               cnt_q[g] <= sesf_pkg::SESF_RST_CNT;
            else if (wr && idx == sesf_pkg::SESF_IDX_CNT0 + 8'(g))
               cnt_q[g] <= wb_dat_i[7:0];
         end
      end
   endgenerate
   assign cnt_load = wr && idx <= sesf_pkg::SESF_IDX_CNT2;

   // Masks, expected phase, control
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mask0_q <= sesf_pkg::SESF_RST_MASK;
         mask1_q <= sesf_pkg::SESF_RST_MASK;
         exp_phase_q <= sesf_pkg::SESF_RST_PHASE;
         ctrl_q <= sesf_pkg::SESF_RST_CTRL;
      end
      else if (wr)
      begin
         if (idx == sesf_pkg::SESF_IDX_MASK0)
            mask0_q <= wb_dat_i[7:0];
         if (idx == sesf_pkg::SESF_IDX_MASK1)
            mask1_q <= wb_dat_i[7:0];
         if (idx == sesf_pkg::SESF_IDX_SIGNAL)
            exp_phase_q <= wb_dat_i[2:0];
         if (idx == sesf_pkg::SESF_IDX_CTRL0 || idx == sesf_pkg::SESF_IDX_CTRL)
            ctrl_q <= wb_dat_i[7:0];
      end
   end

   assign phase_wr = wr && idx == sesf_pkg::SESF_IDX_SIGNAL;
   assign par_clr = wr && idx == sesf_pkg::SESF_IDX_MASK1
                    && !wb_dat_i[sesf_pkg::SESF_M1_PARITY_EN];
   assign bf_clr = wr && idx == sesf_pkg::SESF_IDX_MASK1
                   && !wb_dat_i[sesf_pkg::SESF_M1_BUS_FREE_EN];

   // ***********************************************************
   // Bus edge detection
   // ***********************************************************
   logic [2:0] phase_q;
   logic req_q;
   logic ack_in_q;
   logic atn_q;
   logic free_q;
   logic bus_free;
   assign bus_free = !scsi_bsy_i && !scsi_sel_i;

   // Previous samples of bus lines
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase_q <= 3'h0;
         req_q <= 1'b0;
         ack_in_q <= 1'b0;
         atn_q <= 1'b0;
         free_q <= 1'b0;
      end
      else
      begin
         phase_q <= scsi_phase_i;
         req_q <= scsi_req_i;
         ack_in_q <= scsi_ack_i;
         atn_q <= scsi_atn_i;
         free_q <= bus_free;
      end
   end

   logic phase_chg;
   logic req_rise;
   logic ack_rise;
   logic atn_rise;
   logic free_rise;
   assign phase_chg = phase_q != scsi_phase_i;
   assign req_rise = scsi_req_i && !req_q;
   assign ack_rise = scsi_ack_i && !ack_in_q;
   assign atn_rise = scsi_atn_i && !atn_q;
   assign free_rise = bus_free && !free_q;

   // ***********************************************************
   // Status flags
   // ***********************************************************
   logic cnt_zero;
   logic phase_q_flag;
   logic req_seen_q;
   logic par_q;
   logic bf_q;
   logic wrong_q;
   logic set_phase;
   logic set_req;
   logic set_par;
   logic set_wrong;
   logic [2:0] exp_now;
   assign cnt_zero = cnt_q[0] == 8'h00 && cnt_q[1] == 8'h00 && cnt_q[2] == 8'h00;
   assign set_phase = target ? atn_rise : phase_chg;
   assign set_req = !target && req_rise;
   assign set_par = parity_err_i && mask1_q[sesf_pkg::SESF_M1_PARITY_EN];
   // A phase write counts at once, so a matching write is never overruled by the set
   assign exp_now = phase_wr ? wb_dat_i[2:0] : exp_phase_q;
   assign set_wrong = !target && scsi_req_i && scsi_phase_i != exp_now;

   // Phase change or attention; set wins over ACK clear
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         phase_q_flag <= 1'b0;
      else if (set_phase)
         phase_q_flag <= 1'b1;
      else if (!target && ack_rise)
         phase_q_flag <= 1'b0;
   end

   // Request seen
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         req_seen_q <= 1'b0;
      else if (set_req)
         req_seen_q <= 1'b1;
      else if (ack_rise)
         req_seen_q <= 1'b0;
   end

   // Parity, bus free, wrong phase
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         par_q <= 1'b0;
         bf_q <= 1'b0;
         wrong_q <= 1'b0;
      end
      else
      begin
         if (set_par)
            par_q <= 1'b1;
         else if (par_clr)
            par_q <= 1'b0;
         if (free_rise)
            bf_q <= 1'b1;
         else if (bf_clr)
            bf_q <= 1'b0;
         if (set_wrong)
            wrong_q <= 1'b1;
         else if (phase_wr && wb_dat_i[2:0] == scsi_phase_i)
            wrong_q <= 1'b0;
      end
   end

   logic [7:0] status0;
   logic error_sum;
   // Status byte assembled from field positions
   always_comb
   begin
      status0 = 8'h00;
      status0[sesf_pkg::SESF_ST_CNT_ZERO] = cnt_zero;
      status0[sesf_pkg::SESF_ST_PHASE_ATN] = phase_q_flag;
      status0[sesf_pkg::SESF_ST_REQ_SEEN] = req_seen_q;
      status0[sesf_pkg::SESF_ST_PARITY] = par_q;
      status0[sesf_pkg::SESF_ST_BUS_FREE] = bf_q;
      status0[sesf_pkg::SESF_ST_WRONG_PHASE] = wrong_q;
   end
   assign error_sum = par_q || bf_q || wrong_q;

   // ***********************************************************
   // Auto attention and interrupt
   // ***********************************************************
   logic atn_drv_q;
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         atn_drv_q <= 1'b0;
      else if (!target && par_q && mask0_q[sesf_pkg::SESF_M0_AUTO_ATTENTION_ON_PARITY])
         atn_drv_q <= 1'b1;
      else if (!par_q)
         atn_drv_q <= 1'b0;
   end
   assign scsi_atn_o = atn_drv_q;
   assign scsi_atn_oe_o = atn_drv_q;
   assign int_o = error_sum || (req_seen_q && mask1_q[sesf_pkg::SESF_M1_REQ_EN]);

   // ***********************************************************
   // Read data
   // ***********************************************************
   logic [7:0] rd_d;
   logic [31:0] rdat_q;
   always_comb
   begin
      rd_d = 8'h00;
      case (idx)
         sesf_pkg::SESF_IDX_CNT0: rd_d = cnt_q[0];
         sesf_pkg::SESF_IDX_CNT1: rd_d = cnt_q[1];
         sesf_pkg::SESF_IDX_CNT2: rd_d = cnt_q[2];
         sesf_pkg::SESF_IDX_MASK0: rd_d = mask0_q;
         sesf_pkg::SESF_IDX_MASK1: rd_d = mask1_q;
         sesf_pkg::SESF_IDX_STAT0: rd_d = status0;
         sesf_pkg::SESF_IDX_STAT1: rd_d = 8'(error_sum) << sesf_pkg::SESF_ST1_ERROR;
         sesf_pkg::SESF_IDX_SIGNAL: rd_d = {5'h00, scsi_phase_i};
         sesf_pkg::SESF_IDX_CTRL: rd_d = ctrl_q;
         default: rd_d = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         rdat_q <= 32'h0000_0000;
      else if (acc && !wb_we_i)
         rdat_q <= {24'h000000, rd_d};
   end
   assign wb_dat_o = rdat_q;

   // ***********************************************************
   // Checks
   // ***********************************************************
   // Flag set and clear behaviour
   count_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (cnt_q[0] == 8'h00 && cnt_q[1] == 8'h00 && cnt_q[2] == 8'h00) |-> status0[0])
      else $error("count zero flag wrong");
   phase_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (!target && phase_chg) |=> phase_q_flag)
      else $error("phase flag not set");
   req_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (ack_rise && !set_req) |=> !req_seen_q)
      else $error("request flag not cleared");
   par_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      set_par |=> par_q && int_o)
      else $error("parity flag or interrupt missing");
   par_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (par_clr && !set_par) |=> !par_q)
      else $error("parity flag not cleared");
   free_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      free_rise |=> bf_q && error_sum)
      else $error("bus free flag not set");
   wrong_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      set_wrong |=> wrong_q)
      else $error("mismatch flag not set");
   target_req_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (target && !req_seen_q) |=> !req_seen_q)
      else $error("request flag moved in target role");

   // Clear paths and role gating
   cnt_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (cnt_load && wb_dat_i[7:0] != 8'h00) |=> !status0[sesf_pkg::SESF_ST_CNT_ZERO])
      else $error("count zero flag not cleared by load");
   phase_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (!target && ack_rise && !phase_chg) |=> !phase_q_flag)
      else $error("phase flag not cleared by ack");
   target_atn_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (target && atn_rise) |=> phase_q_flag)
      else $error("attention flag not set in target role");
   req_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (!target && req_rise) |=> req_seen_q)
      else $error("request flag not set");
   free_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (bf_clr && !free_rise) |=> !bf_q)
      else $error("bus free flag not cleared");
   wrong_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (phase_wr && wb_dat_i[2:0] == scsi_phase_i) |=> !wrong_q)
      else $error("mismatch flag not cleared");
   target_wrong_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (target && !wrong_q) |=> !wrong_q)
      else $error("mismatch flag moved in target role");

   // Read path
   summary_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (acc && !wb_we_i && idx == sesf_pkg::SESF_IDX_STAT1 && (bf_q || wrong_q))
      |=> wb_dat_o[sesf_pkg::SESF_ST1_ERROR])
      else $error("summary bit missing on read");

   // Auto attention after a latched parity error
   sequence par_latched_s;
      set_par ##1 (par_q && !target && mask0_q[sesf_pkg::SESF_M0_AUTO_ATTENTION_ON_PARITY]);
   endsequence
   auto_attention_on_parity_a: assert property (@(posedge clock_i) disable iff (rst_i)
      par_latched_s |=> scsi_atn_o && scsi_atn_oe_o)
      else $error("auto attention not driven");
endmodule

// ==== tb/sesf_scsi_model.sv ====
`timescale 1ns/1ps
// ***********************************************************
// SCSI bus peer model
// ***********************************************************
module sesf_scsi_model (
   input wire logic clock_i,
   input wire logic [2:0] phase_cmd_i,
   input wire logic req_cmd_i,
   input wire logic ack_cmd_i,
   input wire logic atn_cmd_i,
   input wire logic bsy_cmd_i,
   input wire logic sel_cmd_i,
   input wire logic perr_cmd_i,
   output logic [2:0] phase_o,
   output logic req_o,
   output logic ack_o,
   output logic atn_o,
   output logic bsy_o,
   output logic sel_o,
   output logic perr_o
);
   // Bus lines follow the bench commands one edge later
   always_ff @(posedge clock_i)
   begin
      phase_o <= phase_cmd_i;
      req_o <= req_cmd_i;
      ack_o <= ack_cmd_i;
      atn_o <= atn_cmd_i;
      bsy_o <= bsy_cmd_i;
      sel_o <= sel_cmd_i;
      perr_o <= perr_cmd_i & ~perr_o; // Single-cycle error pulse
   end
endmodule

// ==== tb/sesf_flags_tb.sv ====
`timescale 1ns/1ps
// ***********************************************************
// Bench for the status flag block
// ***********************************************************
module sesf_flags_tb;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic ack_o, atn_o, atn_oe_o, int_o;
   logic [2:0] ph_c = 3'h0;
   logic [2:0] ph;
   logic req_c = 1'b0, ack_c = 1'b0, atn_c = 1'b0, bsy_c = 1'b1, perr_c = 1'b0, sel_c = 1'b0;
   logic [3:0] sel_b = 4'hF;
   logic req, ack, atn, bsy, sel, perr;
   int failures = 0;
   int samples_checked = 0;
   int exp0 = 1;

   sesf_flags dut (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel_b), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
      .scsi_req_i(req), .scsi_ack_i(ack), .scsi_atn_i(atn), .scsi_bsy_i(bsy), .scsi_sel_i(sel),
      .scsi_phase_i(ph), .parity_err_i(perr), .scsi_atn_o(atn_o), .scsi_atn_oe_o(atn_oe_o), .int_o(int_o));

   sesf_scsi_model peer (.clock_i(clock_i), .phase_cmd_i(ph_c), .req_cmd_i(req_c), .ack_cmd_i(ack_c),
      .atn_cmd_i(atn_c), .bsy_cmd_i(bsy_c), .sel_cmd_i(sel_c), .perr_cmd_i(perr_c), .phase_o(ph), .req_o(req),
      .ack_o(ack), .atn_o(atn), .bsy_o(bsy), .sel_o(sel), .perr_o(perr));

   // Clock, 100 ns period
   always #50 clock_i = ~clock_i;

   task end_sim;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, want, seen);
      end
   endtask

   // Classic single cycle, waits for ack; the watchdog bounds a hang
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= idx << 2;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clock_i);
      end
      while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock_i);
   endtask

   task settle;
      repeat (3) @(posedge clock_i);
   endtask

   // Reads both status registers against the model
   task st(input string n);
      bus(1'b0, sesf_pkg::SESF_IDX_STAT0, 8'h00);
      check(n, rdat, exp0);
      bus(1'b0, sesf_pkg::SESF_IDX_STAT1, 8'h00);
      check("summary", rdat, (exp0 & 32'h38) != 0 ? 32'h10 : 32'h0);
   endtask

   // Main sequence
   initial
   begin
      void'($urandom(32'h0B63B532));
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      st("reset");
      ph_c <= 3'h1;
      exp0 |= 32'h02;
      settle;
      st("phase change");
      req_c <= 1'b1;
      exp0 |= 32'h24;
      settle;
      st("req wrong phase");
      ack_c <= 1'b1;
      exp0 &= ~32'h06;
      settle;
      st("ack clears");
      req_c <= 1'b0;
      ack_c <= 1'b0;
      bus(1'b1, sesf_pkg::SESF_IDX_SIGNAL, 8'h02);
      st("other phase");
      bus(1'b1, sesf_pkg::SESF_IDX_SIGNAL, 8'h01);
      exp0 &= ~32'h20;
      st("matching phase");
      bus(1'b1, sesf_pkg::SESF_IDX_CNT1, 8'($urandom % 255 + 1));
      exp0 &= ~32'h01;
      st("count load");
      bus(1'b1, sesf_pkg::SESF_IDX_CNT1, 8'h00);
      exp0 |= 32'h01;
      st("count zero");
      sel_b <= 4'hE;
      bus(1'b1, sesf_pkg::SESF_IDX_CNT0, 8'h5A);
      sel_b <= 4'hF;
      st("lane off write");
      req_c <= 1'b1;
      exp0 |= 32'h04;
      bus(1'b1, sesf_pkg::SESF_IDX_MASK1, 8'h40);
      settle;
      st("req seen again");
      check("req int", {31'h0, int_o}, 32'h1);
      req_c <= 1'b0;
      ack_c <= 1'b1;
      exp0 &= ~32'h04;
      settle;
      st("req cleared");
      check("req int off", {31'h0, int_o}, 32'h0);
      ack_c <= 1'b0;
      bsy_c <= 1'b0;
      exp0 |= 32'h10;
      settle;
      st("bus free");
      bus(1'b1, sesf_pkg::SESF_IDX_MASK1, 8'h00);
      exp0 &= ~32'h10;
      st("bus free clear");
      sel_c <= 1'b1;
      settle;
      sel_c <= 1'b0;
      exp0 |= 32'h10;
      settle;
      st("free after select");
      bsy_c <= 1'b1;
      bus(1'b1, sesf_pkg::SESF_IDX_MASK0, 8'h10);
      bus(1'b1, sesf_pkg::SESF_IDX_MASK1, 8'h02);
      exp0 &= ~32'h10;
      st("enable write clears free");
      perr_c <= 1'b1;
      @(posedge clock_i);
      perr_c <= 1'b0;
      exp0 |= 32'h08;
      settle;
      check("int", {31'h0, int_o}, 32'h1);
      check("atn", {30'h0, atn_o, atn_oe_o}, 32'h3);
      st("parity");
      bus(1'b1, sesf_pkg::SESF_IDX_MASK1, 8'h00);
      exp0 &= ~32'h08;
      st("parity clear");
      check("int off", {31'h0, int_o}, 32'h0);
      check("atn off", {30'h0, atn_o, atn_oe_o}, 32'h0);
      bus(1'b1, sesf_pkg::SESF_IDX_CTRL0, 8'h01);
      st("control write");
      atn_c <= 1'b1;
      exp0 |= 32'h02;
      settle;
      st("target atn");
      bus(1'b0, 8'h0F, 8'h00);
      check("unmapped", rdat, 32'h0);
      end_sim;
   end

   // Watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge clock_i);
      failures++;
      end_sim;
   end
endmodule
